// ==== src/headphone_amp_control_regs.sv ====
// headphone amplifier control registers, load and stereo sensing, jack detect debounce
`include "hp_amp_consts.svh"

module headphone_amp_control_regs #(
   parameter int unsigned JACK_BASE_CYCLES = `HP_JACK_BASE_CYCLES
) (
   input  wire logic                 core_clk,
   input  wire logic                 rst,
   input  wire logic [7:0]           reg_addr,
   input  wire logic                 reg_write,
   input  wire logic                 reg_read,
   input  wire logic [7:0]           reg_wdata,
   output logic      [7:0]           reg_rdata,
   output logic                      reg_rvalid,
   input  wire logic                 sample_valid,
   input  wire logic [1:0]           sample_sign,
   input  wire logic                 stereo_comp_in,
   input  wire logic                 left_load_comp_in,
   input  wire logic                 right_load_comp_in,
   input  wire logic                 jack_comp_in,
   output hp_amp_pkg::amp_out_t      left_out,
   output hp_amp_pkg::amp_out_t      right_out,
   output logic                      stereo_sense_enable,
   output logic                      load_sense_enable,
   output logic                      differential_output_select,
   output hp_amp_pkg::jack_cfg_t     jack_cfg,
   output logic                      jack_present
);

   // ************************************************************
   // storage
   // ************************************************************

   // register contents, index 0 is left and 1 is right
   hp_amp_pkg::amp_ctrl_t ctrl [2];
   logic [5:0]            gain_code [2];
   logic [5:0]            applied [2];
   logic [1:0]            sense_en;
   logic                  diff_sel;
   logic [7:0]            jack_cfg_reg;
   logic [2:0]            jack_ctrl_reg;

   // comparator synchronisers and sensing status
   logic [3:0]            sync_a;
   logic [3:0]            sync_b;
   logic                  stereo_headset_flag;
   logic                  left_load_flag;
   logic                  right_load_flag;
   logic                  jack_comp;

   // jack measurement interval and insertion debounce
   logic [19:0]           meas_count;
   logic                  meas_tick;
   logic [2:0]            deb_count;
   logic [2:0]            deb_need;

   // read data and write strobes
   logic [7:0]            next_rdata;
   logic                  wr_left;
   logic                  wr_right;

   // control register write strobes
   assign wr_left  = reg_write && (reg_addr == `HP_OFS_LEFT_CTRL);
   assign wr_right = reg_write && (reg_addr == `HP_OFS_RIGHT_CTRL);

   // ************************************************************
   // amplifier control registers
   // ************************************************************

   // left control register, same layout as the right one
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ctrl[0].enable     <= 1'b0;
         ctrl[0].mute       <= 1'b1; // RULE16
         ctrl[0].ramp       <= 1'b0;
         ctrl[0].zero_cross <= 1'b0;
         ctrl[0].drive      <= 1'b0;
         ctrl[0].force_min  <= 1'b0;
      end else if (wr_left) begin
         ctrl[0].enable     <= reg_wdata[`HP_BIT_ENABLE];     // RULE16
         ctrl[0].mute       <= reg_wdata[`HP_BIT_MUTE];
         ctrl[0].ramp       <= reg_wdata[`HP_BIT_RAMP];
         ctrl[0].zero_cross <= reg_wdata[`HP_BIT_ZERO_CROSS];
         ctrl[0].drive      <= reg_wdata[`HP_BIT_DRIVE];
         ctrl[0].force_min  <= reg_wdata[`HP_BIT_FORCE_MIN];
      end
   end

   // right control register
   // reset leaves the amplifier disabled, muted and undriven
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ctrl[1].enable     <= 1'b0; // RULE5
         ctrl[1].mute       <= 1'b1; // RULE6
         ctrl[1].ramp       <= 1'b0;
         ctrl[1].zero_cross <= 1'b0;
         ctrl[1].drive      <= 1'b0; // RULE9
         ctrl[1].force_min  <= 1'b0;
      end else if (wr_right) begin
         ctrl[1].enable     <= reg_wdata[`HP_BIT_ENABLE];     // RULE5
         ctrl[1].mute       <= reg_wdata[`HP_BIT_MUTE];       // RULE6
         ctrl[1].ramp       <= reg_wdata[`HP_BIT_RAMP];       // RULE7
         ctrl[1].zero_cross <= reg_wdata[`HP_BIT_ZERO_CROSS]; // RULE8
         ctrl[1].drive      <= reg_wdata[`HP_BIT_DRIVE];      // RULE9
         ctrl[1].force_min  <= reg_wdata[`HP_BIT_FORCE_MIN];  // RULE10
      end
   end

   // gain registers, stored as written
   always_ff @(posedge core_clk) begin
      if (rst) begin
         gain_code[0] <= `HP_GAIN_RESET; // RULE1
         gain_code[1] <= `HP_GAIN_RESET; // RULE4
      end else if (reg_write && reg_addr == `HP_OFS_LEFT_GAIN) begin
         gain_code[0] <= reg_wdata[5:0]; // RULE1
      end else if (reg_write && reg_addr == `HP_OFS_RIGHT_GAIN) begin
         gain_code[1] <= reg_wdata[5:0]; // RULE4
      end
   end

   // sense enables and output mode
   always_ff @(posedge core_clk) begin
      if (rst) begin
         sense_en <= 2'h0;
         diff_sel <= 1'b0;
      end else if (reg_write && reg_addr == `HP_OFS_SNGL_CTRL) begin
         sense_en <= {reg_wdata[`HP_BIT_STEREO_EN], reg_wdata[`HP_BIT_LOAD_EN]}; // RULE11 RULE13
      end else if (reg_write && reg_addr == `HP_OFS_DIFF_CTRL) begin
         diff_sel <= reg_wdata[`HP_BIT_DIFF_SEL]; // RULE15
      end
   end

   // jack detect configuration registers
   // of the control register only bits 7, 1 and 0 are kept
   always_ff @(posedge core_clk) begin
      if (rst) begin
         jack_cfg_reg  <= `HP_JACK_CFG_RESET;
         jack_ctrl_reg <= 3'h0;
      end else if (reg_write && reg_addr == `HP_OFS_JACK_CFG) begin
         jack_cfg_reg <= reg_wdata;
      end else if (reg_write && reg_addr == `HP_OFS_JACK_CTRL) begin
         jack_ctrl_reg <= {reg_wdata[`HP_BIT_DISCHARGE], reg_wdata[`HP_BIT_HYST],
                           reg_wdata[`HP_BIT_COMP_INV]};
      end
   end

   // ************************************************************
   // gain application, one stepper per channel
   // ************************************************************

   // channel 0 is left, channel 1 is right
   // the stepper holds the live gain, the gain register is its shadow
   for (genvar ch = 0; ch < 2; ch++) begin : g_chan
      gain_stepper u_stepper (
         .core_clk     (core_clk),
         .rst          (rst),
         .target       (gain_code[ch]),
         .ramp         (ctrl[ch].ramp),       // RULE7
         .zero_cross   (ctrl[ch].zero_cross), // RULE8
         .force_min    (ctrl[ch].force_min),  // RULE10
         .sample_valid (sample_valid),
         .sample_sign  (sample_sign[ch]),
         .applied_gain (applied[ch])
      );
   end

   // amplifier commands, registered
   always_ff @(posedge core_clk) begin
      if (rst) begin
         left_out  <= '{enable: 1'b0, mute: 1'b1, drive: 1'b0, gain: `HP_GAIN_RESET};
         right_out <= '{enable: 1'b0, mute: 1'b1, drive: 1'b0, gain: `HP_GAIN_RESET};
      end else begin
         left_out  <= '{enable: ctrl[0].enable, mute: ctrl[0].mute,
                        drive: ctrl[0].drive, gain: applied[0]};   // RULE16
         right_out <= '{enable: ctrl[1].enable, mute: ctrl[1].mute,
                        drive: ctrl[1].drive, gain: applied[1]};   // RULE5 RULE6 RULE9
      end
   end

   // enables and output mode go straight from their register bits
   assign stereo_sense_enable        = sense_en[1];
   assign load_sense_enable          = sense_en[0];
   assign differential_output_select = diff_sel;

   // jack configuration handed to the detector
   always_ff @(posedge core_clk) begin
      if (rst) begin
         jack_cfg <= '0;
      end else begin
         jack_cfg <= '{enable:     jack_cfg_reg[`HP_BIT_JACK_EN],
                       threshold:  jack_cfg_reg[`HP_MSB_JACK_THR:`HP_LSB_JACK_THR],
                       discharge:  jack_ctrl_reg[2],
                       hysteresis: jack_ctrl_reg[1]};
      end
   end

   // ************************************************************
   // comparator inputs and sensing status
   // ************************************************************

   // two-flop synchronisers for the analog comparators
   // only sync_b feeds logic, sync_a may still be settling
   always_ff @(posedge core_clk) begin
      if (rst) begin
         sync_a <= 4'h0;
         sync_b <= 4'h0;
      end else begin
         sync_a <= {jack_comp_in, right_load_comp_in, left_load_comp_in, stereo_comp_in};
         sync_b <= sync_a;
      end
   end

   // status reads clear while the matching sense function is off
   // the inversion bit applies to the jack comparator only
   always_ff @(posedge core_clk) begin
      if (rst) begin
         stereo_headset_flag <= 1'b0;
         left_load_flag      <= 1'b0;
         right_load_flag     <= 1'b0;
         jack_comp           <= 1'b0;
      end else begin
         stereo_headset_flag <= sense_en[1] & sync_b[0]; // RULE12
         left_load_flag      <= sense_en[0] & sync_b[1]; // RULE14
         right_load_flag     <= sense_en[0] & sync_b[2]; // RULE14
         jack_comp           <= sync_b[3] ^ jack_ctrl_reg[0];
      end
   end

   // ************************************************************
   // jack detection with insertion debounce
   // ************************************************************

   // measurement interval is the base interval doubled per rate code
   always_ff @(posedge core_clk) begin
      if (rst || !jack_cfg_reg[`HP_BIT_JACK_EN] || meas_tick) begin
         meas_count <= 20'h00000;
      end else begin
         meas_count <= meas_count + 20'h00001;
      end
   end

   // tick on the last cycle of each interval
   assign meas_tick = (meas_count == 20'((JACK_BASE_CYCLES << jack_cfg_reg[`HP_MSB_JACK_RATE:`HP_LSB_JACK_RATE])
                                         - 1));

   // code 0 needs one measurement, codes 1..3 need 2..4
   assign deb_need  = (jack_cfg_reg[`HP_MSB_JACK_DEB:`HP_LSB_JACK_DEB] == 2'h0) ? 3'h1
                    : {1'b0, jack_cfg_reg[`HP_MSB_JACK_DEB:`HP_LSB_JACK_DEB]} + 3'h1;

   // insertion counts consecutive high measurements, removal clears at once
   // a low comparator wins over a tick in the same cycle
   always_ff @(posedge core_clk) begin
      if (rst || !jack_cfg_reg[`HP_BIT_JACK_EN]) begin
         deb_count    <= 3'h0;
         jack_present <= 1'b0;
      end else if (!jack_comp) begin
         deb_count    <= 3'h0;
         jack_present <= 1'b0; // RULE17
      end else if (meas_tick && !jack_present) begin
         if (deb_count + 3'h1 >= deb_need) begin
            jack_present <= 1'b1; // RULE17
         end else begin
            deb_count <= deb_count + 3'h1;
         end
      end
   end

   // ************************************************************
   // read port
   // ************************************************************

   // read data mux, reserved bits and unmapped offsets read zero
   always_comb begin
      next_rdata = 8'h00;
      unique case (reg_addr)
         `HP_OFS_LEFT_CTRL:   next_rdata = {ctrl[0], 2'h0};
         `HP_OFS_LEFT_GAIN:   next_rdata = {2'h0, gain_code[0]};
         `HP_OFS_RIGHT_CTRL:  next_rdata = {ctrl[1], 2'h0};
         `HP_OFS_RIGHT_GAIN:  next_rdata = {2'h0, gain_code[1]};
         `HP_OFS_SNGL_CTRL:   next_rdata = {sense_en, 3'h0, right_load_flag, left_load_flag,
                                            stereo_headset_flag}; // RULE12 RULE14
         `HP_OFS_DIFF_CTRL:   next_rdata = {7'h00, diff_sel};
         `HP_OFS_JACK_CFG:    next_rdata = jack_cfg_reg;
         `HP_OFS_JACK_CTRL:   next_rdata = {jack_ctrl_reg[2], 5'h00, jack_ctrl_reg[1:0]};
         `HP_OFS_JACK_STATUS: next_rdata = {3'h0, jack_comp, 4'h0};
         default:             next_rdata = 8'h00;
      endcase
   end

   // read answer one cycle after the strobe
   // reg_rdata holds its value until the next read
   always_ff @(posedge core_clk) begin
      if (rst) begin
         reg_rdata  <= 8'h00;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_read;
         if (reg_read) begin
            reg_rdata <= next_rdata;
         end
      end
   end

endmodule : headphone_amp_control_regs

// ==== src/hp_amp_consts.svh ====
// offsets, field positions, reset values and timing counts of the headphone amplifier register bank
// What this block does
// RULE1 - left gain field bits 5:0, 1.5 dB per code, resets to 0x3b
// RULE2 - gain codes 0x00 to 0x14 are reserved and must not be programmed
// RULE3 - code 0x15 is -57 dB, each code adds 1.5 dB, 0x3f is +6 dB
// RULE4 - right gain field bits 5:0, same steps, resets to 0x3b
// RULE5 - right control bit 7 enables right amplifier, resets clear
// RULE6 - right control bit 6 mutes right amplifier, resets set
// RULE7 - right bit 5 ramps gain changes and overrides zero-cross gating
// RULE8 - right bit 4 defers gain change to data zero crossing when not ramping
// RULE9 - right bit 3 drives the output, clear leaves it high impedance
// RULE10 - right bit 2 forces minimum gain regardless of the programmed code
// RULE11 - single-ended control bit 7 enables stereo headset detection, resets clear
// RULE12 - read-only bit 0 reports headset type, 1 stereo, 0 mono
// RULE13 - single-ended control bit 6 enables load detection on both outputs
// RULE14 - read-only bits 2 and 1 report right and left load present
// RULE15 - differential control bit 0 clear selects single-ended, set is reserved
// RULE16 - left control holds the same six control bits at 7 down to 2
// RULE17 - jack insertion confirmed after debounce measurements, removal reported at once
// RULE18 - zero-cross update held in shadow, applied on first data sign change
`ifndef HP_AMP_CONSTS_SVH
`define HP_AMP_CONSTS_SVH

// register offsets
`define HP_OFS_LEFT_CTRL     8'hd0
`define HP_OFS_LEFT_GAIN     8'hd1
`define HP_OFS_RIGHT_CTRL    8'hd2
`define HP_OFS_RIGHT_GAIN    8'hd3
`define HP_OFS_SNGL_CTRL     8'hd4
`define HP_OFS_DIFF_CTRL     8'hd5
`define HP_OFS_JACK_CFG      8'hd8
`define HP_OFS_JACK_CTRL     8'hd9
`define HP_OFS_JACK_STATUS   8'hda

// amplifier control field positions
`define HP_BIT_ENABLE        7
`define HP_BIT_MUTE          6
`define HP_BIT_RAMP          5
`define HP_BIT_ZERO_CROSS    4
`define HP_BIT_DRIVE         3
`define HP_BIT_FORCE_MIN     2

// single-ended and differential fields
`define HP_BIT_STEREO_EN     7
`define HP_BIT_LOAD_EN       6
`define HP_BIT_LOAD_RIGHT    2
`define HP_BIT_LOAD_LEFT     1
`define HP_BIT_STEREO_FLAG   0
`define HP_BIT_DIFF_SEL      0

// jack detect fields
`define HP_BIT_JACK_EN       7
`define HP_MSB_JACK_THR      6
`define HP_LSB_JACK_THR      5
`define HP_MSB_JACK_DEB      4
`define HP_LSB_JACK_DEB      3
`define HP_MSB_JACK_RATE     2
`define HP_LSB_JACK_RATE     0
`define HP_BIT_DISCHARGE     7
`define HP_BIT_HYST          1
`define HP_BIT_COMP_INV      0
`define HP_BIT_COMP_STATUS   4

// gain codes and reset values
`define HP_GAIN_RESET        6'h3b
`define HP_GAIN_MIN          6'h15
`define HP_CTRL_RESET        8'h40
`define HP_JACK_CFG_RESET    8'h0b

// timing: shortest jack measurement interval at the 20 MHz core clock
`define HP_CLK_HZ            20000000
`define HP_JACK_BASE_NS      5000
`define HP_JACK_BASE_CYCLES  ((`HP_JACK_BASE_NS * (`HP_CLK_HZ / 1000000)) / 1000)

`endif

// ==== src/hp_amp_pkg.sv ====
// types shared by the headphone amplifier register bank
package hp_amp_pkg;

   // control bits of one amplifier channel
   typedef struct packed {
      logic enable;
      logic mute;
      logic ramp;
      logic zero_cross;
      logic drive;
      logic force_min;
   } amp_ctrl_t;

   // what one amplifier channel is told to do
   typedef struct packed {
      logic       enable;
      logic       mute;
      logic       drive;
      logic [5:0] gain;
   } amp_out_t;

   // jack detect configuration handed to the analog detector
   typedef struct packed {
      logic       enable;
      logic [1:0] threshold;
      logic       discharge;
      logic       hysteresis;
   } jack_cfg_t;

endpackage : hp_amp_pkg

// ==== src/gain_stepper.sv ====
// per-channel gain application: instant, ramped, zero-cross deferred, forced minimum
`include "hp_amp_consts.svh"

module gain_stepper (
   input  wire logic       core_clk,
   input  wire logic       rst,
   input  wire logic [5:0] target,
   input  wire logic       ramp,
   input  wire logic       zero_cross,
   input  wire logic       force_min,
   input  wire logic       sample_valid,
   input  wire logic       sample_sign,
   output logic      [5:0] applied_gain
);

   logic [5:0] active;
   logic [5:0] safe_target;
   logic       last_sign;
   logic       sign_change;

   // reserved codes below the bottom of the scale are clamped to it
   assign safe_target = (target < `HP_GAIN_MIN) ? `HP_GAIN_MIN : target; // RULE2
   assign sign_change = sample_valid && (sample_sign != last_sign);

   // remember the sign of the last audio sample
   always_ff @(posedge core_clk) begin
      if (rst) begin
         last_sign <= 1'b0;
      end else if (sample_valid) begin
         last_sign <= sample_sign;
      end
   end

   // move the live gain toward the register value (register is the shadow)
   always_ff @(posedge core_clk) begin
      if (rst) begin
         active <= `HP_GAIN_RESET;
      end else if (ramp) begin
         if (sample_valid && active < safe_target) begin
            active <= active + 6'h01; // RULE7
         end else if (sample_valid && active > safe_target) begin
            active <= active - 6'h01; // RULE7
         end
      end else if (zero_cross) begin
         if (sign_change) begin
            active <= safe_target; // RULE8 RULE18
         end
      end else begin
         active <= safe_target; // RULE3
      end
   end

   // minimum gain overrides the live gain
   always_ff @(posedge core_clk) begin
      if (rst) begin
         applied_gain <= `HP_GAIN_RESET;
      end else begin
         applied_gain <= force_min ? `HP_GAIN_MIN : active; // RULE10
      end
   end

endmodule : gain_stepper

// ==== bench/hp_amp_chk.sv ====
// concurrent checks on the headphone amplifier register bank ports
module hp_amp_chk (
   input wire logic                 core_clk,
   input wire logic                 rst,
   input wire logic [7:0]           reg_addr,
   input wire logic                 reg_write,
   input wire logic                 reg_read,
   input wire logic [7:0]           reg_wdata,
   input wire logic [7:0]           reg_rdata,
   input wire logic                 reg_rvalid,
   input wire hp_amp_pkg::amp_out_t left_out,
   input wire hp_amp_pkg::amp_out_t right_out,
   input wire logic                 stereo_sense_enable,
   input wire logic                 load_sense_enable,
   input wire logic                 differential_output_select
);
   timeunit 1ns;
   timeprecision 1ps;
   // ***********************************
   // port relations, all on core_clk
   // ***********************************
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);

   property p_left_gain_read;
      reg_read && reg_addr == 8'hd1 |=> reg_rvalid && reg_rdata[7:6] == 2'h0;
   endproperty
   a_left_gain_read: assert property (p_left_gain_read)
      else $error("left gain read not answered or upper bits set");
   property p_right_gain_back;
      (reg_write && reg_addr == 8'hd3) ##1 (reg_read && !reg_write && reg_addr == 8'hd3)
         |=> reg_rdata == {2'h0, $past(reg_wdata[5:0], 2)};
   endproperty
   a_right_gain_back: assert property (p_right_gain_back)
      else $error("right gain readback differs from written code");
   property p_right_ctrl;
      reg_write && reg_addr == 8'hd2 |-> ##2 right_out.enable == $past(reg_wdata[7], 2)
         && right_out.mute == $past(reg_wdata[6], 2) && right_out.drive == $past(reg_wdata[3], 2);
   endproperty
   a_right_ctrl: assert property (p_right_ctrl)
      else $error("right amplifier controls do not follow the write");
   property p_left_ctrl;
      reg_write && reg_addr == 8'hd0 |-> ##2 left_out.enable == $past(reg_wdata[7], 2)
         && left_out.mute == $past(reg_wdata[6], 2) && left_out.drive == $past(reg_wdata[3], 2);
   endproperty
   a_left_ctrl: assert property (p_left_ctrl)
      else $error("left amplifier controls do not follow the write");
   property p_force_min;
      (reg_write && reg_addr == 8'hd2 && reg_wdata[2]) ##1 (!reg_write)[*5] |-> right_out.gain == 6'h15;
   endproperty
   a_force_min: assert property (p_force_min)
      else $error("forced minimum gain not applied");
   property p_sense_en;
      reg_write && reg_addr == 8'hd4 |=> {stereo_sense_enable, load_sense_enable} == $past(reg_wdata[7:6]);
   endproperty
   a_sense_en: assert property (p_sense_en)
      else $error("sense enables do not follow the write");
   property p_status_idle;
      (!load_sense_enable && !stereo_sense_enable)[*4] ##0 (reg_read && reg_addr == 8'hd4)
         |=> reg_rdata[5:0] == 6'h00;
   endproperty
   a_status_idle: assert property (p_status_idle)
      else $error("sense status set while sensing is off");
   property p_diff;
      reg_write && reg_addr == 8'hd5 |=> differential_output_select == $past(reg_wdata[0]);
   endproperty
   a_diff: assert property (p_diff)
      else $error("output mode select does not follow the write");
endmodule : hp_amp_chk

// ==== bench/headphone_amp_control_regs_tb.sv ====
// self-checking bench for the headphone amplifier register bank
module headphone_amp_control_regs_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic                  core_clk, rst, reg_write, reg_read, reg_rvalid, sample_valid, jack_present;
   logic                  stereo_comp_in, left_load_comp_in, right_load_comp_in, jack_comp_in;
   logic                  stereo_sense_enable, load_sense_enable, differential_output_select;
   logic [7:0]            reg_addr, reg_wdata, reg_rdata;
   logic [1:0]            sample_sign;
   hp_amp_pkg::amp_out_t  left_out, right_out;
   hp_amp_pkg::jack_cfg_t jack_cfg;
   logic [7:0]            exp_q[$];
   logic [5:0]            rg, ng;
   int                    n_fail, checks_done, i;

   headphone_amp_control_regs #(.JACK_BASE_CYCLES(4)) u_headphone_amp_control_regs (
      .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_write(reg_write), .reg_read(reg_read),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .sample_valid(sample_valid),
      .sample_sign(sample_sign), .stereo_comp_in(stereo_comp_in), .left_load_comp_in(left_load_comp_in),
      .right_load_comp_in(right_load_comp_in), .jack_comp_in(jack_comp_in), .left_out(left_out),
      .right_out(right_out), .stereo_sense_enable(stereo_sense_enable), .load_sense_enable(load_sense_enable),
      .differential_output_select(differential_output_select), .jack_cfg(jack_cfg), .jack_present(jack_present));

   // ***********************************
   // tasks
   // ***********************************
   task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr = a; reg_wdata = d; reg_write = 1'b1; reg_read = 1'b0;
      @(negedge core_clk);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      reg_addr = a; reg_read = 1'b1; reg_write = 1'b0;
      exp_q.push_back(e);
      @(negedge core_clk);
   endtask : rd
   task automatic idle(input int n);
      reg_write = 1'b0; reg_read = 1'b0;
      repeat (n) @(negedge core_clk);
   endtask : idle
   task automatic pulse(input logic [1:0] s);
      sample_sign = s; sample_valid = 1'b1;
      @(negedge core_clk);
      sample_valid = 1'b0;
      idle(3);
   endtask : pulse
   task automatic end_sim;
      if (n_fail == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : end_sim

   // ***********************************
   // clock, watchdog, read monitor, tests
   // ***********************************
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   initial begin
      repeat (5000) @(posedge core_clk);
      n_fail++;
      end_sim();
   end
   // compares each read answer with the oldest noted value
   always @(posedge core_clk) if (reg_rvalid === 1'b1) check("reg_rdata", reg_rdata, exp_q.pop_front());
   initial begin
      rst = 1'b1; reg_addr = 8'h00; reg_wdata = 8'h00; reg_write = 1'b0; reg_read = 1'b0;
      sample_valid = 1'b0; sample_sign = 2'h0; stereo_comp_in = 1'b0; left_load_comp_in = 1'b0;
      right_load_comp_in = 1'b0; jack_comp_in = 1'b0; n_fail = 0; checks_done = 0;
      void'($urandom(74330));
      repeat (12) @(posedge core_clk);
      @(negedge core_clk);
      rst = 1'b0;
      // reset values, unmapped offset last
      check("right_out", right_out, 9'h0bb);
      check("left_out", left_out, 9'h0bb);
      rd(8'hd0, 8'h40);
      rd(8'hd1, 8'h3b);
      rd(8'hd2, 8'h40);
      rd(8'hd3, 8'h3b);
      rd(8'hd4, 8'h00);
      rd(8'hd5, 8'h00);
      rd(8'hd8, 8'h0b);
      rd(8'hd6, 8'h00);
      // random legal gain codes, reserved bits written random
      for (i = 0; i < 6; i++) begin
         rg = 6'h15 + 6'($urandom_range(42, 0));
         ng = 6'h15 + 6'($urandom_range(42, 0));
         wr(8'hd3, {2'($urandom), rg});
         rd(8'hd3, {2'h0, rg});
         wr(8'hd1, {2'($urandom), ng});
         rd(8'hd1, {2'h0, ng});
         idle(4);
         check("right_gain", right_out.gain, rg);
         check("left_gain", left_out.gain, ng);
      end
      wr(8'hd2, 8'h8b);
      rd(8'hd2, 8'h88);
      wr(8'hd0, 8'hcb);
      rd(8'hd0, 8'hc8);
      idle(3);
      check("right_out", right_out, {3'b101, rg});
      check("left_out", left_out, {3'b111, ng});
      wr(8'hd3, 8'h05);
      rd(8'hd3, 8'h05);
      idle(4);
      check("right_gain", right_out.gain, 6'h15);
      rg = 6'h1a + 6'($urandom_range(34, 0));
      wr(8'hd3, {2'h0, rg});
      wr(8'hd2, 8'h8c);
      idle(5);
      check("right_gain", right_out.gain, 6'h15);
      wr(8'hd2, 8'h88);
      idle(5);
      check("right_gain", right_out.gain, rg);
      // ramp with zero-cross also set: steps on every sample
      wr(8'hd2, 8'hb8);
      wr(8'hd3, {2'h0, rg + 6'h03});
      idle(6);
      check("right_gain", right_out.gain, rg);
      for (i = 1; i < 4; i++) begin
         pulse(2'h0);
         check("right_gain", right_out.gain, rg + 6'(i));
      end
      rg = rg + 6'h03;
      ng = rg - 6'h05;
      wr(8'hd2, 8'h98);
      wr(8'hd3, {2'h0, ng});
      idle(5);
      check("right_gain", right_out.gain, rg);
      pulse(2'h0);
      check("right_gain", right_out.gain, rg);
      pulse(2'h2);
      check("right_gain", right_out.gain, ng);
      // sensing status, disabled then enabled
      stereo_comp_in = 1'b1; right_load_comp_in = 1'b1;
      idle(6);
      rd(8'hd4, 8'h00);
      wr(8'hd4, 8'hff);
      idle(6);
      rd(8'hd4, 8'hc5);
      stereo_comp_in = 1'b0; right_load_comp_in = 1'b0; left_load_comp_in = 1'b1;
      idle(6);
      rd(8'hd4, 8'hc2);
      wr(8'hd4, 8'h00);
      wr(8'hd5, 8'hfe);
      rd(8'hd5, 8'h00);
      check("diff_select", differential_output_select, 1'b0);
      wr(8'hd5, 8'h00);
      // jack insertion with two measurements, removal at once
      wr(8'hd9, 8'h00);
      wr(8'hd8, 8'h88);
      idle(2);
      check("jack_cfg", jack_cfg, 5'h10);
      jack_comp_in = 1'b1;
      idle(2);
      check("jack_present", jack_present, 1'b0);
      for (i = 0; i < 30 && jack_present !== 1'b1; i++) @(negedge core_clk);
      check("jack_present", jack_present, 1'b1);
      rd(8'hda, 8'h10);
      jack_comp_in = 1'b0;
      idle(5);
      check("jack_present", jack_present, 1'b0);
      idle(4);
      check("read_queue", 9'(exp_q.size()), 9'h000);
      end_sim();
   end
endmodule : headphone_amp_control_regs_tb

bind headphone_amp_control_regs hp_amp_chk u_hp_amp_chk (
   .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_write(reg_write), .reg_read(reg_read),
   .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .left_out(left_out),
   .right_out(right_out), .stereo_sense_enable(stereo_sense_enable), .load_sense_enable(load_sense_enable),
   .differential_output_select(differential_output_select));
